// [frame_sync_generator.sv]
// Purpose: Frame sync pulse source for two return links
// Assumes: Host writes registers over the serial control bus,
//   decoded into the byte register port below
// Notes: Per-port registers are reached through reg_port_sel
//
// Operation
// - The internal generator runs only while its enable bit is 1.
// - Source codes 0x8 to 0xE pass pin 0 to 6 with the generator off.
// - A return link signal carries sync only when its route selects it.
// - External pulses reach the links within about one frame period.
// - Both return links are updated on the same common frame strobe.
// - A generator tick is one return link frame of 30 bit times.
// - While enabled the generator emits periodic pulses without end.
// - In internal mode the source field picks the port giving the tick.
// - The duty style bit picks 50/50 or separate high and low counts.
// - The starting level bit sets the generator's first output level.
// - Each phase lasts its programmed count plus one ticks.
// - High and low counts are 16 bits, upper byte at the lower address.
// - Rate code 110b selects the 50 Mbps return link rate.
`timescale 1ns/1ps
module frame_sync_generator #(
  parameter int PIN_COUNT = 7,
  parameter int PORT_COUNT = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [1:0] reg_port_sel,
  output logic [7:0] reg_rd_data,
  input wire logic [PIN_COUNT-1:0] gpio_pin,
  output logic sync_level,
  output logic [1:0] return_link_signal_p0,
  output logic [1:0] return_link_signal_p1
);
  logic [7:0] control_ff;
  logic [15:0] high_count_ff;
  logic [15:0] low_count_ff;
  logic [7:0] route_ff [PORT_COUNT];
  logic [2:0] rate_ff [PORT_COUNT];
  logic [PORT_COUNT-1:0] frame_strobe;
  logic [PIN_COUNT-1:0] pin_s1_ff;
  logic [PIN_COUNT-1:0] pin_s2_ff;
  logic [PIN_COUNT-1:0] pin_s3_ff;
  logic [PIN_COUNT-1:0] pin_ok_ff;
  logic gen_level_ff;
  logic [15:0] phase_cnt_ff;
  logic [1:0] link_out_ff [PORT_COUNT];
  logic internal_generator_on;
  logic duty_style_select;
  logic starting_level;
  logic [3:0] sync_source_select;
  logic ext_mode;
  logic [2:0] pin_idx;
  logic tick;
  logic src_level;
  logic [15:0] low_eff;
  logic [7:0] nxt_rd_data;
  logic rd_port;

  assign internal_generator_on = control_ff[sync_pulse_pkg::GEN_ON_BIT];
  assign duty_style_select = control_ff[sync_pulse_pkg::DUTY_STYLE_BIT];
  assign starting_level = control_ff[sync_pulse_pkg::START_LEVEL_BIT];
  assign sync_source_select = control_ff[sync_pulse_pkg::SOURCE_LSB +: 4];
  assign rd_port = !reg_port_sel[0];

  // Control and count registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_ff <= sync_pulse_pkg::CONTROL_RESET;
      high_count_ff <= {2{sync_pulse_pkg::COUNT_RESET}};
      low_count_ff <= {2{sync_pulse_pkg::COUNT_RESET}};
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        sync_pulse_pkg::SYNC_PULSE_CONTROL_ADDR: begin
          control_ff <= reg_wr_data;
        end
        sync_pulse_pkg::HIGH_COUNT_UPPER_ADDR: begin
          high_count_ff[15:8] <= reg_wr_data;
        end
        sync_pulse_pkg::HIGH_COUNT_LOWER_ADDR: begin
          high_count_ff[7:0] <= reg_wr_data;
        end
        sync_pulse_pkg::LOW_COUNT_UPPER_ADDR: begin
          low_count_ff[15:8] <= reg_wr_data;
        end
        sync_pulse_pkg::LOW_COUNT_LOWER_ADDR: begin
          low_count_ff[7:0] <= reg_wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  // Per-port rate, route, frame tick and link output
  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        route_ff[p] <= sync_pulse_pkg::ROUTE_RESET;
        rate_ff[p] <= sync_pulse_pkg::RATE_RESET;
      end else if (reg_wr_en && reg_port_sel[p]) begin
        if (reg_addr == sync_pulse_pkg::SIGNAL_ROUTE_ADDR) begin
          route_ff[p] <= reg_wr_data;
        end
        if (reg_addr == sync_pulse_pkg::RATE_SEL_ADDR) begin
          rate_ff[p] <= reg_wr_data[2:0];
        end
      end
    end

    frame_tick u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .rate_sel(rate_ff[p]),
      .frame_strobe(frame_strobe[p])
    );

    for (genvar s = 0; s < 2; s++) begin : g_sig
      // Both links load on the common tick
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          link_out_ff[p][s] <= 1'b0;
        end else if (tick) begin
          link_out_ff[p][s] <= (route_ff[p][s*4 +: 4] ==
            sync_pulse_pkg::ROUTE_SYNC_SEL) && src_level;
        end
      end
    end
  end

  assign return_link_signal_p0 = link_out_ff[0];
  assign return_link_signal_p1 = link_out_ff[1];

  // Tick from the chosen port's frame period
  always_comb begin
    if (internal_generator_on &&
        sync_source_select == sync_pulse_pkg::SRC_TICK_PORT1) begin
      tick = frame_strobe[1];
    end else begin
      tick = frame_strobe[0];
    end
  end

  // Pin inputs, three flops, accepted when the last two agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= gpio_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        pin_ok_ff[i] <= 1'b0;
      end else if (pin_s2_ff[i] == pin_s3_ff[i]) begin
        pin_ok_ff[i] <= pin_s3_ff[i];
      end
    end
  end

  assign ext_mode = !internal_generator_on &&
    sync_source_select >= sync_pulse_pkg::SRC_PIN_FIRST &&
    sync_source_select <= sync_pulse_pkg::SRC_PIN_LAST;
  assign pin_idx = 3'(sync_source_select - sync_pulse_pkg::SRC_PIN_FIRST);

  always_comb begin
    if (internal_generator_on) begin
      src_level = gen_level_ff;
    end else if (ext_mode) begin
      src_level = pin_ok_ff[pin_idx];
    end else begin
      src_level = 1'b0;
    end
  end

  // 50/50 style reuses the high count for the low phase
  assign low_eff = duty_style_select ? high_count_ff : low_count_ff;

  // Phase generator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gen_level_ff <= 1'b0;
      phase_cnt_ff <= 16'h0000;
    end else if (!internal_generator_on) begin
      gen_level_ff <= starting_level;
      phase_cnt_ff <= starting_level ? high_count_ff : low_eff;
    end else if (tick) begin
      if (phase_cnt_ff == 16'h0000) begin
        gen_level_ff <= !gen_level_ff;
        phase_cnt_ff <= gen_level_ff ? low_eff : high_count_ff;
      end else begin
        phase_cnt_ff <= phase_cnt_ff - 16'h0001;
      end
    end
  end

  assign sync_level = gen_level_ff;

  // Read mux, answered one cycle after the strobe
  always_comb begin
    nxt_rd_data = 8'h00;
    unique case (reg_addr)
      sync_pulse_pkg::SYNC_PULSE_CONTROL_ADDR: begin
        nxt_rd_data = control_ff;
        nxt_rd_data[sync_pulse_pkg::LEVEL_STATUS_BIT] = gen_level_ff;
      end
      sync_pulse_pkg::HIGH_COUNT_UPPER_ADDR: begin
        nxt_rd_data = high_count_ff[15:8];
      end
      sync_pulse_pkg::HIGH_COUNT_LOWER_ADDR: begin
        nxt_rd_data = high_count_ff[7:0];
      end
      sync_pulse_pkg::LOW_COUNT_UPPER_ADDR: begin
        nxt_rd_data = low_count_ff[15:8];
      end
      sync_pulse_pkg::LOW_COUNT_LOWER_ADDR: begin
        nxt_rd_data = low_count_ff[7:0];
      end
      sync_pulse_pkg::SIGNAL_ROUTE_ADDR: begin
        nxt_rd_data = route_ff[rd_port];
      end
      sync_pulse_pkg::RATE_SEL_ADDR: begin
        nxt_rd_data = {5'h00, rate_ff[rd_port]};
      end
      default: begin
        nxt_rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data <= nxt_rd_data;
    end
  end

  property p_hold_when_off;
    @(posedge sys_clk) disable iff (rst)
    !internal_generator_on |=> gen_level_ff == $past(starting_level);
  endproperty
  a_hold_when_off: assert property (p_hold_when_off)
    else $error("Generator level moved while disabled");

  property p_toggle_on_tick_only;
    @(posedge sys_clk) disable iff (rst)
    internal_generator_on && !tick && $past(internal_generator_on)
      |=> $stable(gen_level_ff);
  endproperty
  a_toggle_on_tick_only: assert property (p_toggle_on_tick_only)
    else $error("Generator level changed without a tick");

  property p_reload_phase;
    @(posedge sys_clk) disable iff (rst)
    internal_generator_on && tick && phase_cnt_ff == 16'h0000
      |=> gen_level_ff != $past(gen_level_ff) &&
        phase_cnt_ff == ($past(gen_level_ff) ? $past(low_eff)
                                              : $past(high_count_ff));
  endproperty
  a_reload_phase: assert property (p_reload_phase)
    else $error("Phase count not reloaded on expiry");

  property p_route_gate;
    @(posedge sys_clk) disable iff (rst)
    tick && route_ff[0][3:0] != sync_pulse_pkg::ROUTE_SYNC_SEL
      |=> !return_link_signal_p0[0];
  endproperty
  a_route_gate: assert property (p_route_gate)
    else $error("Unrouted link signal carries sync");

  property p_links_together;
    @(posedge sys_clk) disable iff (rst)
    tick && route_ff[0] == route_ff[1]
      |=> return_link_signal_p0 == return_link_signal_p1;
  endproperty
  a_links_together: assert property (p_links_together)
    else $error("Return links updated apart");

  property p_ext_follow;
    @(posedge sys_clk) disable iff (rst)
    tick && ext_mode && route_ff[1][3:0] == sync_pulse_pkg::ROUTE_SYNC_SEL
      |=> return_link_signal_p1[0] == $past(pin_ok_ff[pin_idx]);
  endproperty
  a_ext_follow: assert property (p_ext_follow)
    else $error("External pin level not forwarded");

  property p_ext_within_frame;
    @(posedge sys_clk) disable iff (rst)
    ext_mode && route_ff[0][3:0] == sync_pulse_pkg::ROUTE_SYNC_SEL &&
      rate_ff[0] == sync_pulse_pkg::RATE_50MBPS && $rose(pin_ok_ff[pin_idx])
      ##1 ext_mode && pin_ok_ff[pin_idx] [*8]
      |-> ##[0:30] return_link_signal_p0[0];
  endproperty
  a_ext_within_frame: assert property (p_ext_within_frame)
    else $error("External pulse late on return link");

  property p_ext_follow_p0;
    @(posedge sys_clk) disable iff (rst)
    tick && ext_mode && route_ff[0][7:4] == sync_pulse_pkg::ROUTE_SYNC_SEL
      |=> return_link_signal_p0[1] == $past(pin_ok_ff[pin_idx]);
  endproperty
  a_ext_follow_p0: assert property (p_ext_follow_p0)
    else $error("External pin level not forwarded on port 0");

  property p_count_down;
    @(posedge sys_clk) disable iff (rst)
    internal_generator_on && tick && phase_cnt_ff != 16'h0000
      |=> phase_cnt_ff == $past(phase_cnt_ff) - 16'h0001 &&
        $stable(gen_level_ff);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("Phase count did not step down on a tick");

  property p_off_preload;
    @(posedge sys_clk) disable iff (rst)
    !internal_generator_on
      |=> phase_cnt_ff == ($past(starting_level) ? $past(high_count_ff)
                                                  : $past(low_eff));
  endproperty
  a_off_preload: assert property (p_off_preload)
    else $error("Phase count not preloaded while disabled");

  property p_link_hold;
    @(posedge sys_clk) disable iff (rst)
    !tick |=> $stable(return_link_signal_p0) &&
      $stable(return_link_signal_p1);
  endproperty
  a_link_hold: assert property (p_link_hold)
    else $error("Return link changed between ticks");

  property p_idle_source_quiet;
    @(posedge sys_clk) disable iff (rst)
    tick && !internal_generator_on && !ext_mode
      |=> return_link_signal_p0 == 2'h0 && return_link_signal_p1 == 2'h0;
  endproperty
  a_idle_source_quiet: assert property (p_idle_source_quiet)
    else $error("Return link driven with no sync source");
endmodule

// [sync_pulse_pkg.sv]
// Purpose: Shared constants for the frame sync pulse generator
// Assumes: 8-bit register port, 40 MHz system clock
// Notes: Offsets are the printed register addresses
package sync_pulse_pkg;
  localparam logic [7:0] SYNC_PULSE_CONTROL_ADDR = 8'h18;
  localparam logic [7:0] HIGH_COUNT_UPPER_ADDR = 8'h19;
  localparam logic [7:0] HIGH_COUNT_LOWER_ADDR = 8'h1a;
  localparam logic [7:0] LOW_COUNT_UPPER_ADDR = 8'h1b;
  localparam logic [7:0] LOW_COUNT_LOWER_ADDR = 8'h1c;
  localparam logic [7:0] RATE_SEL_ADDR = 8'h58;
  localparam logic [7:0] SIGNAL_ROUTE_ADDR = 8'h6e;

  // Control register fields, rate and route field widths
  localparam int GEN_ON_BIT = 0;
  localparam int DUTY_STYLE_BIT = 1;
  localparam int START_LEVEL_BIT = 2;
  localparam int LEVEL_STATUS_BIT = 3;
  localparam int SOURCE_LSB = 4;
  localparam int RATE_WIDTH = 3;
  localparam int ROUTE_FIELD_W = 4;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [2:0] RATE_RESET = 3'h0;

  // Source codes and the route code for sync
  localparam logic [3:0] SRC_TICK_PORT0 = 4'h0;
  localparam logic [3:0] SRC_TICK_PORT1 = 4'h1;
  localparam logic [3:0] SRC_PIN_FIRST = 4'h8;
  localparam logic [3:0] SRC_PIN_LAST = 4'he;
  localparam logic [3:0] ROUTE_SYNC_SEL = 4'ha;

  // Return link rates; frame is 30 bit times
  localparam logic [2:0] RATE_50MBPS = 3'h6;
  localparam int FRAME_BITS = 30;
  localparam int FRAME_NS_50MBPS = 600;
  localparam int FRAME_NS_2M5BPS = 12000;
  localparam int CLK_MHZ = 40;
  localparam int FRAME_CYC_50MBPS = (FRAME_NS_50MBPS * CLK_MHZ + 999) / 1000;
  localparam int FRAME_CYC_2M5BPS = (FRAME_NS_2M5BPS * CLK_MHZ + 999) / 1000;
  localparam int TICK_CNT_W = 16;
endpackage

// [frame_tick.sv]
// Purpose: Return link frame period strobe for one receive port
// Assumes: Rate code steers the frame length
// Notes: Strobe is one cycle wide, from a flop
`timescale 1ns/1ps
module frame_tick (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [sync_pulse_pkg::RATE_WIDTH-1:0] rate_sel,
  output logic frame_strobe
);
  logic [sync_pulse_pkg::TICK_CNT_W-1:0] cnt_ff;
  logic [sync_pulse_pkg::TICK_CNT_W-1:0] last_cnt;

  // Frame of 30 bit times at the selected rate
  always_comb begin
    if (rate_sel == sync_pulse_pkg::RATE_50MBPS) begin
      last_cnt = 16'(sync_pulse_pkg::FRAME_CYC_50MBPS - 1);
    end else begin
      last_cnt = 16'(sync_pulse_pkg::FRAME_CYC_2M5BPS - 1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff >= last_cnt) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_strobe <= 1'b0;
    end else begin
      frame_strobe <= (cnt_ff >= last_cnt);
    end
  end

  property p_tick_spacing;
    @(posedge sys_clk) disable iff (rst)
    frame_strobe |=> !frame_strobe [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("Frame strobes closer than a frame");
endmodule

// [link_sink.sv]
// Purpose: Far side model of the two serializers fed by the return links
// Assumes: Each serializer only watches signal 0 of its two return link signals
// Notes: Counts signal 0 rising edges and cycles where the two signal 0 lines disagree
`timescale 1ns/1ps
module link_sink (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] sig_p0,
  input wire logic [1:0] sig_p1,
  output logic [15:0] rises_p0,
  output logic [15:0] rises_p1,
  output logic [15:0] split_cycles
);
  logic [1:0] last_p0_ff;
  logic [1:0] last_p1_ff;

  // Reference taken as nominal, so counts arrive unscaled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_p0_ff <= 2'h0;
      last_p1_ff <= 2'h0;
      rises_p0 <= 16'h0000;
      rises_p1 <= 16'h0000;
      split_cycles <= 16'h0000;
    end else begin
      last_p0_ff <= sig_p0;
      last_p1_ff <= sig_p1;
      if (sig_p0[0] && !last_p0_ff[0]) rises_p0 <= rises_p0 + 16'h0001;
      if (sig_p1[0] && !last_p1_ff[0]) rises_p1 <= rises_p1 + 16'h0001;
      if (sig_p0[0] !== sig_p1[0]) split_cycles <= split_cycles + 16'h0001;
    end
  end
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the frame sync pulse generator
// Assumes: Inputs change on the falling edge of a 40 MHz clock
// Notes: Phase lengths are measured in whole clock cycles
`timescale 1ns/1ps
module testbench;
  localparam int F50 = sync_pulse_pkg::FRAME_CYC_50MBPS;
  localparam int FSL = sync_pulse_pkg::FRAME_CYC_2M5BPS;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [1:0] reg_port_sel = 2'h0;
  logic [6:0] gpio_pin = 7'h00;
  logic [7:0] reg_rd_data;
  logic sync_level;
  logic [1:0] return_link_signal_p0;
  logic [1:0] return_link_signal_p1;
  logic [15:0] rises_p0;
  logic [15:0] rises_p1;
  logic [15:0] split_cycles;
  int n_fail = 0;
  int n_tests = 0;

  always #12.5 sys_clk = ~sys_clk;

  frame_sync_generator uut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_port_sel(reg_port_sel),
    .reg_rd_data(reg_rd_data), .gpio_pin(gpio_pin), .sync_level(sync_level),
    .return_link_signal_p0(return_link_signal_p0),
    .return_link_signal_p1(return_link_signal_p1));

  link_sink sink (.sys_clk(sys_clk), .rst(rst),
    .sig_p0(return_link_signal_p0), .sig_p1(return_link_signal_p1),
    .rises_p0(rises_p0), .rises_p1(rises_p1), .split_cycles(split_cycles));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] ps, input logic [7:0] a,
                    input logic [7:0] d);
    @(negedge sys_clk);
    reg_port_sel = ps;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [1:0] ps,
                        input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_port_sel = ps;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    @(negedge sys_clk);
    check(what, {24'h00_0000, reg_rd_data}, {24'h00_0000, exp});
  endtask

  // Cycles until the generator level next changes
  task automatic edge_wait(output int n);
    logic s;
    s = sync_level;
    n = 0;
    while (sync_level === s) begin
      @(negedge sys_clk);
      n++;
      if (n > 2000) begin
        n_fail++;
        $display("[FAIL] generator level never changed");
        report_and_stop();
      end
    end
  endtask

  // Measures one whole phase; expects hi_t or lo_t cycles
  task automatic phase_chk(input string what, input int hi_t, input int lo_t);
    int n;
    edge_wait(n);
    edge_wait(n);
    check(what, n, (sync_level === 1'b0) ? hi_t : lo_t);
  endtask

  task automatic t_registers;
    for (int a = 8'h18; a <= 8'h1c; a++) begin
      rd_chk("reset value", 2'h1, 8'(a), 8'h00);
    end
    wr(2'h1, 8'h30, 8'h55);
    rd_chk("unmapped read", 2'h1, 8'h30, 8'h00);
    wr(2'h0, 8'h19, 8'h0a);
    wr(2'h0, 8'h1a, 8'hd7);
    rd_chk("high upper", 2'h0, 8'h19, 8'h0a);
    rd_chk("high lower", 2'h0, 8'h1a, 8'hd7);
  endtask

  task automatic t_internal;
    wr(2'h3, 8'h58, {5'h00, sync_pulse_pkg::RATE_50MBPS});
    wr(2'h3, 8'h6e, 8'haa);
    wr(2'h0, 8'h19, 8'h00);
    wr(2'h0, 8'h1a, 8'h01);
    wr(2'h0, 8'h1b, 8'h00);
    wr(2'h0, 8'h1c, 8'h02);
    wr(2'h0, 8'h18, 8'h01);
    phase_chk("separate phase a", 2 * F50, 3 * F50);
    phase_chk("separate phase b", 2 * F50, 3 * F50);
    // Links pick up a new level at the following frame tick
    repeat (F50 + 3) @(negedge sys_clk);
    check("port0 follows", return_link_signal_p0, {2{sync_level}});
    check("ports agree", return_link_signal_p1, return_link_signal_p0);
    check("link split", split_cycles, 16'h0000);
    check("pulses keep coming", rises_p0 > 16'h0001, 1'b1);
    check("port1 pulses", rises_p1, rises_p0);
    wr(2'h0, 8'h18, 8'h03);
    phase_chk("even duty a", 2 * F50, 2 * F50);
    phase_chk("even duty b", 2 * F50, 2 * F50);
    wr(2'h1, 8'h58, 8'h00);
    wr(2'h0, 8'h18, 8'h11);
    phase_chk("port1 tick", 2 * F50, 3 * F50);
    wr(2'h0, 8'h18, 8'h01);
    phase_chk("port0 slow tick", 2 * FSL, 3 * FSL);
  endtask

  task automatic t_disabled;
    int changes;
    wr(2'h0, 8'h18, 8'h04);
    repeat (4) @(negedge sys_clk);
    check("start level high", sync_level, 1'b1);
    rd_chk("level status", 2'h0, 8'h18, 8'h0c);
    changes = 0;
    repeat (3 * F50) begin
      @(negedge sys_clk);
      if (sync_level !== 1'b1) changes++;
    end
    check("held while off", changes, 0);
    wr(2'h0, 8'h18, 8'h00);
    repeat (4) @(negedge sys_clk);
    check("start level low", sync_level, 1'b0);
    repeat (3 * F50) @(negedge sys_clk);
    check("stays off", sync_level, 1'b0);
  endtask

  task automatic t_external;
    wr(2'h3, 8'h58, {5'h00, sync_pulse_pkg::RATE_50MBPS});
    wr(2'h1, 8'h6e, 8'haa);
    wr(2'h2, 8'h6e, 8'h0a);
    rd_chk("route port0", 2'h1, 8'h6e, 8'haa);
    rd_chk("route port1", 2'h2, 8'h6e, 8'h0a);
    rd_chk("rate port1", 2'h2, 8'h58,
           {5'h00, sync_pulse_pkg::RATE_50MBPS});
    for (int i = 0; i < 7; i++) begin
      wr(2'h0, 8'h18, {4'(8 + i), 4'h0});
      gpio_pin = ~(7'h01 << i);
      repeat (F50 + 8) @(negedge sys_clk);
      check("other pins ignored", return_link_signal_p0, 2'h0);
      gpio_pin = 7'h01 << i;
      repeat (F50 + 8) @(negedge sys_clk);
      check("pin reaches port0", return_link_signal_p0, 2'h3);
      check("port1 signal0 only", return_link_signal_p1, 2'h1);
      gpio_pin = 7'h00;
      repeat (F50 + 8) @(negedge sys_clk);
      check("pin release", return_link_signal_p0, 2'h0);
    end
    // Code 0xF is no pin source, so links stay low
    wr(2'h0, 8'h18, 8'hf0);
    gpio_pin = 7'h7f;
    repeat (F50 + 8) @(negedge sys_clk);
    check("bad source quiet", return_link_signal_p0, 2'h0);
    gpio_pin = 7'h00;
  endtask

  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    t_registers();
    t_internal();
    t_disabled();
    t_external();
    report_and_stop();
  end
endmodule
